/* src/iirg_gating.sv */
/*
 Interrupt request gating: enable register over APB, flag inputs from the transfer engine,
 four level request outputs and a bit counter field.
 Assumes the engine gives one-cycle pulses for serial clock rise, data load, frame end and overrun.
*/
`timescale 1ns/1ps
`default_nettype none
module iirg_gating
   import iirg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txEmptySet,
   input wire logic txEmptyClear,
   input wire logic sclRise,
   input wire logic rxLoad,
   input wire logic rxRead,
   input wire logic overrunSet,
   input wire logic bitDone,
   input wire logic frameEnd,
   input wire logic syncMode,
   output logic tx_empty_request,
   output logic tx_end_request,
   output logic rx_full_request,
   output logic error_request,
   output logic [2:0] bitCount
);
   logic [7:0] enable_reg, enable_next;
   logic txEmpty_reg, txEnd_reg, rxFull_reg, overrun_reg;
   logic [3:0] clkCount_reg;
   logic [2:0] count_reg, count_next;
   logic [31:0] rdata_next;
   logic txEmptyReq_next, txEndReq_next, rxFullReq_next, errReq_next;

   wire logic access = psel && penable;
   // Writes land only on the edge that completes the transfer
   wire logic xferDone = access && pready;
   wire logic wrEn = xferDone && pwrite && paddr == IIRG_ENABLE_OFFSET;
   wire logic wrFlags = xferDone && pwrite && paddr == IIRG_FLAGS_OFFSET;
   wire logic wrCount = xferDone && pwrite && paddr == IIRG_COUNT_OFFSET;
   wire logic hitEn = paddr == IIRG_ENABLE_OFFSET;
   wire logic hitFlags = paddr == IIRG_FLAGS_OFFSET;
   wire logic hitCount = paddr == IIRG_COUNT_OFFSET;
   wire logic mapped = hitEn || hitFlags || hitCount;
   wire logic txEmptyEn = enable_reg[IIRG_TX_EMPTY_EN_BIT];
   wire logic txEndEn = enable_reg[IIRG_TX_END_EN_BIT];
   wire logic rxFullEn = enable_reg[IIRG_RX_FULL_EN_BIT];
   // Enables as they will stand, so a request never lags its enable by a cycle
   wire logic txEmptyEnNext = enable_next[IIRG_TX_EMPTY_EN_BIT];
   wire logic txEndEnNext = enable_next[IIRG_TX_END_EN_BIT];
   wire logic rxFullEnNext = enable_next[IIRG_RX_FULL_EN_BIT];
   wire logic ninthRise = sclRise && clkCount_reg == IIRG_NINTH_CLOCK - 4'h1;
   // Software clears a flag by writing zero; a hardware set in the same cycle wins
   wire logic clrTxEnd = wrFlags && !pwdata[IIRG_TX_END_FLAG_BIT];
   wire logic clrRxFull = wrFlags && !pwdata[IIRG_RX_FULL_FLAG_BIT];
   wire logic clrOverrun = wrFlags && !pwdata[IIRG_OVERRUN_FLAG_BIT];
   wire logic setTxEnd = ninthRise && txEmpty_reg;

   assign enable_next = wrEn ? pwdata[7:0] : enable_reg;
   assign count_next = wrCount ? pwdata[2:0] :
      frameEnd ? IIRG_COUNT_ZERO :
      (bitDone && count_reg != IIRG_COUNT_ZERO) ? count_reg - 3'h1 : count_reg;
   // Requests reflect the flags as they will stand, so the output flop is the only delay
   assign txEmptyReq_next = (txEmptySet || (txEmpty_reg && !txEmptyClear)) && txEmptyEnNext;
   assign txEndReq_next = (setTxEnd || (txEnd_reg && !clrTxEnd)) && txEndEnNext;
   assign rxFullReq_next = (rxLoad || (rxFull_reg && !(clrRxFull || rxRead))) && rxFullEnNext;
   assign errReq_next = syncMode && rxFullEnNext && (overrunSet || (overrun_reg && !clrOverrun));
   assign rdata_next = !access ? IIRG_READ_ZERO :
      hitEn ? {24'h000000, enable_reg} :
      hitFlags ? {23'h000000, syncMode, txEmpty_reg, txEnd_reg, rxFull_reg, overrun_reg, 4'h0} :
      hitCount ? {29'h00000000, count_reg} : IIRG_READ_ZERO;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enable_reg <= IIRG_ENABLE_RESET;
         count_reg <= IIRG_COUNT_ZERO;
      end else begin
         enable_reg <= enable_next;
         count_reg <= count_next;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txEmpty_reg <= 1'b0;
         txEnd_reg <= 1'b0;
         rxFull_reg <= 1'b0;
         overrun_reg <= 1'b0;
      end else begin
         txEmpty_reg <= txEmptySet || (txEmpty_reg && !txEmptyClear);
         txEnd_reg <= setTxEnd || (txEnd_reg && !clrTxEnd);
         rxFull_reg <= rxLoad || (rxFull_reg && !(clrRxFull || rxRead));
         overrun_reg <= overrunSet || (overrun_reg && !clrOverrun);
      end
   end

   // Serial clock rises counted within a frame to locate the ninth
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clkCount_reg <= 4'h0;
      end else if (frameEnd) begin
         clkCount_reg <= 4'h0;
      end else if (sclRise && clkCount_reg != IIRG_NINTH_CLOCK) begin
         clkCount_reg <= clkCount_reg + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tx_empty_request <= 1'b0;
         tx_end_request <= 1'b0;
         rx_full_request <= 1'b0;
         error_request <= 1'b0;
         bitCount <= IIRG_COUNT_ZERO;
         prdata <= IIRG_READ_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         tx_empty_request <= txEmptyReq_next;
         tx_end_request <= txEndReq_next;
         rx_full_request <= rxFullReq_next;
         error_request <= errReq_next;
         bitCount <= count_next;
         prdata <= rdata_next;
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
      end
   end

   // Registered answer: one wait state, pready high in the second access cycle
   wire logic rdyDone = access && pready;

   tx_empty_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      tx_empty_request == (txEmpty_reg && txEmptyEn))
      else $error("tx empty request not equal to flag and enable");
   tx_end_set_a: assert property (@(posedge sys_clk) disable iff (rst)
      setTxEnd && txEndEn && !wrEn |=> tx_end_request)
      else $error("tx end request missing after ninth clock");
   tx_end_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
      !txEnd_reg || !txEndEn |-> !tx_end_request)
      else $error("tx end request without flag and enable");
   rx_full_set_a: assert property (@(posedge sys_clk) disable iff (rst)
      rxLoad && rxFullEn && !wrEn |=> rx_full_request && rxFull_reg)
      else $error("rx full request missing after load");
   error_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      error_request |-> rxFullEn && overrun_reg && $past(syncMode))
      else $error("error request while not enabled");
   rx_full_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
      !rxFull_reg || !rxFullEn |-> !rx_full_request)
      else $error("rx full request without flag and enable");
   count_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      frameEnd && !wrCount |=> count_reg == IIRG_COUNT_ZERO && bitCount == IIRG_COUNT_ZERO)
      else $error("bit counter not zero after frame");
   rx_full_level_a: assert property (@(posedge sys_clk) disable iff (rst)
      rx_full_request == (rxFull_reg && rxFullEn))
      else $error("rx full request latched beyond flag");
   apb_answer_a: assert property (@(posedge sys_clk) disable iff (rst)
      psel && !penable ##1 access |-> ##1 pready)
      else $error("apb answer late");

   tx_end_seen_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(tx_end_request));
   rx_full_seen_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(rx_full_request));
   error_seen_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(error_request));
   apb_done_c: cover property (@(posedge sys_clk) disable iff (rst) rdyDone && pwrite);
endmodule // iirg_gating
`default_nettype wire

/* src/iirg_pkg.sv */
/*
 Constants for the interrupt request gating block of a two-wire and clocked serial interface.
 Assumes an APB slave with a 32-bit data bus and an external transfer engine that owns the flags.
*/
// Summary of operation
// - Transmit empty request is high while the transmit empty flag and its enable are set.
// - Transmit end flag is set at the ninth clock rise if transmit empty is one.
// - Transmit end request drops once the end flag or its enable is cleared.
// - Receive full request rises when received data loads and the full flag sets.
// - Overrun error request in clocked format is gated by the receive enable.
// - Receive full request drops once the full flag or its enable is cleared.
// - Bit counter holds the bits to send, reads remaining, returns to zero after frame.
package iirg_pkg;
   localparam logic [11:0] IIRG_ENABLE_OFFSET = 12'h000;
   localparam logic [11:0] IIRG_FLAGS_OFFSET = 12'h004;
   localparam logic [11:0] IIRG_COUNT_OFFSET = 12'h008;
   localparam int IIRG_TX_EMPTY_EN_BIT = 7;
   localparam int IIRG_TX_END_EN_BIT = 6;
   localparam int IIRG_RX_FULL_EN_BIT = 5;
   localparam int IIRG_TX_EMPTY_FLAG_BIT = 7;
   localparam int IIRG_TX_END_FLAG_BIT = 6;
   localparam int IIRG_RX_FULL_FLAG_BIT = 5;
   localparam int IIRG_OVERRUN_FLAG_BIT = 4;
   localparam int IIRG_SYNC_MODE_BIT = 8;
   localparam logic [7:0] IIRG_ENABLE_RESET = 8'h00;
   localparam logic [2:0] IIRG_COUNT_ZERO = 3'h0;
   localparam logic [3:0] IIRG_NINTH_CLOCK = 4'h9;
   localparam logic [31:0] IIRG_READ_ZERO = 32'h00000000;
endpackage

/* testbench/tb.sv */
/*
 Self-checking bench for the request gating block: APB access, flag events, requests, counter.
 Assumes the package and gating sources under src/ are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin cmpCount++; if ((s) !== (e)) begin nFail++; \
   $display("Error %s expected %h seen %h", nm, e, s); end end
module tb import iirg_pkg::*; ;
   logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic syncMode = 1'b0, pready, pslverr, txReq, endReq, rxReq, errReq, errSeen;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdData;
   // Event pulses: tx set, tx clear, scl rise, rx load, rx read, overrun, bit, frame end
   logic [7:0] ev = 8'h00;
   logic [2:0] bitCount;
   int nFail = 0;
   int cmpCount = 0;
   always #10 sys_clk = ~sys_clk;
   iirg_gating dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txEmptySet(ev[0]), .txEmptyClear(ev[1]), .sclRise(ev[2]),
      .rxLoad(ev[3]), .rxRead(ev[4]), .overrunSet(ev[5]), .bitDone(ev[6]), .frameEnd(ev[7]),
      .syncMode(syncMode), .tx_empty_request(txReq), .tx_end_request(endReq),
      .rx_full_request(rxReq), .error_request(errReq), .bitCount(bitCount));
   task wrapUp;
      $display("comparisons %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      i = 0;
      // Sampled at the edge, before the slave's own updates land
      do begin @(posedge sys_clk); i++; end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin nFail++; wrapUp(); end
      rdData = prdata; errSeen = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task pulse(input int b);
      @(posedge sys_clk); ev[b] <= 1'b1;
      @(posedge sys_clk); ev[b] <= 1'b0;
   endtask
   task settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task t_reset;
      apb(1'b0, IIRG_ENABLE_OFFSET, 32'h0);
      `CHK("enable", {24'h0, IIRG_ENABLE_RESET}, rdData)
      `CHK("requests", 4'h0, {txReq, endReq, rxReq, errReq})
      apb(1'b0, 12'hffc, 32'h0);
      `CHK("unmapped err", 1'b1, errSeen)
      `CHK("unmapped data", IIRG_READ_ZERO, rdData)
      $display("test reset done");
   endtask
   task t_tx_empty;
      pulse(0); settle;
      `CHK("tx empty masked", 1'b0, txReq)
      apb(1'b1, IIRG_ENABLE_OFFSET, 32'h80); settle;
      `CHK("tx empty on", 1'b1, txReq)
      pulse(1); settle;
      `CHK("tx empty off", 1'b0, txReq)
      $display("test tx empty done");
   endtask
   task t_tx_end;
      apb(1'b1, IIRG_ENABLE_OFFSET, 32'h40);
      pulse(0);
      repeat (8) pulse(2);
      settle;
      `CHK("tx end at 8", 1'b0, endReq)
      pulse(2); settle;
      `CHK("tx end at 9", 1'b1, endReq)
      apb(1'b0, IIRG_FLAGS_OFFSET, 32'h0);
      `CHK("flags", 32'h000000c0, rdData)
      apb(1'b1, IIRG_FLAGS_OFFSET, 32'hffffffbf); settle;
      `CHK("tx end cleared", 1'b0, endReq)
      pulse(7); pulse(1);
      repeat (9) pulse(2);
      settle;
      `CHK("tx end no empty", 1'b0, endReq)
      $display("test tx end done");
   endtask
   task t_rx;
      apb(1'b1, IIRG_ENABLE_OFFSET, 32'h20);
      pulse(3); settle;
      `CHK("rx full on", 1'b1, rxReq)
      pulse(4); settle;
      `CHK("rx full read", 1'b0, rxReq)
      pulse(5); settle;
      `CHK("overrun not sync", 1'b0, errReq)
      @(posedge sys_clk); syncMode <= 1'b1;
      settle;
      `CHK("overrun sync", 1'b1, errReq)
      pulse(5); settle;
      `CHK("overrun on", 1'b1, errReq)
      apb(1'b1, IIRG_ENABLE_OFFSET, 32'h0); settle;
      `CHK("overrun masked", 1'b0, errReq)
      pulse(3); settle;
      `CHK("rx full masked", 1'b0, rxReq)
      $display("test rx done");
   endtask
   task t_count;
      apb(1'b1, IIRG_COUNT_OFFSET, 32'h5);
      apb(1'b0, IIRG_COUNT_OFFSET, 32'h0);
      `CHK("count write", 32'h5, rdData)
      pulse(6); settle;
      `CHK("count left", 3'h4, bitCount)
      pulse(7); settle;
      `CHK("count end", IIRG_COUNT_ZERO, bitCount)
      $display("test count done");
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset; t_tx_empty; t_tx_end; t_rx; t_count;
      wrapUp;
   end
endmodule // tb
`default_nettype wire
